// [hw/sci_pkg.sv]
// shared constants and carrier types of the serial register map and rate generator
package sci_pkg;

  // divisor width and rate generator shape
  localparam int unsigned DIV_W = 13;
  localparam int unsigned PRESCALE = 64;
  localparam int unsigned OVERSAMPLE = 16;

  // two apertures onto the same registers, byte address = base + 4 * index
  localparam logic [11:0] BLOCK_BASE = 12'h200;
  localparam logic [11:0] NONBLOCK_BASE = 12'h300;

  // register indexes as printed
  localparam logic [7:0] IDX_BAUD_HI = 8'h18;
  localparam logic [7:0] IDX_BAUD_LO = 8'h19;
  localparam logic [7:0] IDX_CTRL_ONE = 8'h1A;
  localparam logic [7:0] IDX_CTRL_TWO = 8'h1B;
  localparam logic [7:0] IDX_STAT_ONE = 8'h1C;
  localparam logic [7:0] IDX_STAT_TWO = 8'h1D;
  localparam logic [7:0] IDX_CTRL_THREE = 8'h1E;
  localparam logic [7:0] IDX_DATA = 8'h1F;

  // field positions
  localparam int unsigned BIT_BRK_IE = 7;
  localparam int unsigned BIT_EDGE_IE = 6;
  localparam int unsigned HI_DIV_BITS = 5;
  localparam int unsigned BIT_TX_ON = 3;
  localparam int unsigned BIT_RX_ON = 2;
  localparam int unsigned BIT_BRK_FLAG = 7;
  localparam int unsigned BIT_EDGE_FLAG = 6;
  localparam int unsigned BIT_RX_NINTH = 7;
  localparam int unsigned BIT_RX_ACTIVE = 0;

  // writable bits of each byte; the rest read as zero or as live state
  localparam logic [7:0] CTRL_ONE_MASK = 8'hB7;
  localparam logic [7:0] STAT_TWO_RW_MASK = 8'h1E;
  localparam logic [7:0] CTRL_THREE_RW_MASK = 8'h7F;

  // reset values
  localparam logic [7:0] LOW_DIV_RST = 8'h04;
  localparam logic [4:0] HI_DIV_RST = 5'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // axi answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // read channel states
  typedef enum logic [0:0] {
    RD_IDLE = 1'b0,
    RD_ANSWER = 1'b1
  } rd_state_e;

  // state reported by the serial engine
  typedef struct packed {
    logic [7:0] status_one; // transmit/receive status byte
    logic [7:0] rx_data;    // last received character
    logic rx_ninth;         // ninth received bit
    logic rx_active;        // receiver busy
    logic break_seen;       // pulse: break character detected
    logic edge_seen;        // pulse: active edge on receive input
  } sci_in_s;

  // settings and strobes towards the serial engine
  typedef struct packed {
    logic [7:0] ctrl_one;   // options byte
    logic [7:0] ctrl_two;   // enables byte
    logic [7:0] ctrl_three; // extra options byte
    logic [7:0] stat_cfg;   // writable bits of second status byte
    logic [7:0] tx_data;    // character to send
    logic tx_write;         // pulse: tx_data loaded
    logic rx_read;          // pulse: data register read
    logic irq_break;        // interrupt request, break detect
    logic irq_edge;         // interrupt request, receive edge
  } sci_out_s;

endpackage : sci_pkg

// [hw/rate_gen.sv]
// modulo divisor and prescaler that make the serial bit rate
module rate_gen #(
  parameter int unsigned DIV_W = sci_pkg::DIV_W
) (
  input wire logic aclk,               // bus clock
  input wire logic aresetn,            // synchronous reset, active low
  input wire logic enable,             // generator allowed to run
  input wire logic [DIV_W-1:0] divisor, // working divisor
  output logic running,                // generator counting
  output logic os_tick,                // pulse at sixteen times bit rate
  output logic bit_tick                // pulse at bit rate
);

  localparam int unsigned PH_W = $clog2(sci_pkg::PRESCALE);
  localparam logic [PH_W-1:0] OS_MASK = PH_W'(sci_pkg::PRESCALE / sci_pkg::OVERSAMPLE - 1);
  localparam logic [PH_W-1:0] PH_LAST = PH_W'(sci_pkg::PRESCALE - 1);

  typedef struct packed {
    logic [DIV_W-1:0] pre;
    logic [PH_W-1:0] phase;
    logic running;
    logic os_tick;
    logic bit_tick;
  } gen_state_s;

  gen_state_s st_ff;
  gen_state_s nxt_st;

  if (DIV_W < 1 || (sci_pkg::PRESCALE % sci_pkg::OVERSAMPLE) != 0) begin : g_bad_cfg
    $error("rate_gen: unusable divisor width or prescale");
  end

  // zero divisor or disabled: counters frozen at zero so nothing toggles
  always_comb begin
    nxt_st = st_ff;
    nxt_st.os_tick = 1'b0;
    nxt_st.bit_tick = 1'b0;
    nxt_st.running = enable && (divisor != '0);
    if (!nxt_st.running) begin
      nxt_st.pre = '0;
      nxt_st.phase = '0;
    end else if (st_ff.pre >= divisor - DIV_W'(1)) begin
      // clk / (64 * divisor) at the last phase
      nxt_st.pre = '0;
      nxt_st.phase = st_ff.phase + PH_W'(1);
      nxt_st.os_tick = (st_ff.phase & OS_MASK) == OS_MASK;
      nxt_st.bit_tick = st_ff.phase == PH_LAST;
    end else begin
      nxt_st.pre = st_ff.pre + DIV_W'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign running = st_ff.running;
  assign os_tick = st_ff.os_tick;
  assign bit_tick = st_ff.bit_tick;

endmodule : rate_gen

// [hw/sci_regs.sv]
// serial interface register file with axi4-lite slave and rate divisor
//////////////////////////////////////////////////////////////////////////////

module sci_regs #(
  parameter int unsigned ADDR_W = 12
) (
  input wire logic aclk,                    // bus clock
  input wire logic aresetn,                 // synchronous reset, active low
  input wire logic [ADDR_W-1:0] awaddr,     // write address
  input wire logic [2:0] awprot,            // write protection, unused
  input wire logic awvalid,                 // write address valid
  output logic awready,                     // write address ready
  input wire logic [31:0] wdata,            // write data
  input wire logic [3:0] wstrb,             // write byte enables
  input wire logic wvalid,                  // write data valid
  output logic wready,                      // write data ready
  output logic [1:0] bresp,                 // write response
  output logic bvalid,                      // write response valid
  input wire logic bready,                  // write response ready
  input wire logic [ADDR_W-1:0] araddr,     // read address
  input wire logic [2:0] arprot,            // read protection, unused
  input wire logic arvalid,                 // read address valid
  output logic arready,                     // read address ready
  output logic [31:0] rdata,                // read data
  output logic [1:0] rresp,                 // read response
  output logic rvalid,                      // read data valid
  input wire logic rready,                  // read data ready
  input wire sci_pkg::sci_in_s sci_in,      // serial engine state
  output sci_pkg::sci_out_s sci_out,        // serial engine settings
  output logic rate_running,                // rate generator counting
  output logic os_tick,                     // oversample pulse
  output logic bit_tick                     // bit rate pulse
);

  localparam int unsigned DIV_W = sci_pkg::DIV_W;
  localparam int unsigned LO_W = DIV_W - sci_pkg::HI_DIV_BITS;

  if (ADDR_W < 10 || ADDR_W > 32 || LO_W != 8) begin : g_bad_cfg
    $error("sci_regs: address width must cover both apertures");
  end

  //////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    // write channel
    logic awready;
    logic wready;
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [7:0] w_byte;
    logic w_lane;
    logic bvalid;
    logic [1:0] bresp;
    // read channel
    sci_pkg::rd_state_e rd_state;
    logic arready;
    logic [7:0] rdata;
    logic [1:0] rresp;
    // divisor and enables
    logic brk_ie;
    logic edge_ie;
    logic [4:0] hi_buf;
    logic [4:0] div_hi;
    logic [7:0] div_lo;
    logic started;
    // flags
    logic brk_flag;
    logic edge_flag;
    // towards the serial engine
    sci_pkg::sci_out_s out;
  } regs_state_s;

  regs_state_s st_ff;
  regs_state_s nxt_st;

  logic gen_running;
  logic gen_os;
  logic gen_bit;

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // maps a byte address to a register slot; both apertures alias
  function automatic logic [3:0] decode(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] rel_b;
    logic [ADDR_W-1:0] rel_n;
    logic [3:0] res;
    rel_b = addr - ADDR_W'(sci_pkg::BLOCK_BASE);
    rel_n = addr - ADDR_W'(sci_pkg::NONBLOCK_BASE);
    res = 4'h0;
    if (rel_b[1:0] == 2'h0 && rel_b[ADDR_W-1:2] >= (ADDR_W-2)'(sci_pkg::IDX_BAUD_HI)
        && rel_b[ADDR_W-1:2] <= (ADDR_W-2)'(sci_pkg::IDX_DATA)) begin
      res = {1'b1, rel_b[4:2]};
    end else if (rel_n[1:0] == 2'h0
        && rel_n[ADDR_W-1:2] >= (ADDR_W-2)'(sci_pkg::IDX_BAUD_HI)
        && rel_n[ADDR_W-1:2] <= (ADDR_W-2)'(sci_pkg::IDX_DATA)) begin
      res = {1'b1, rel_n[4:2]};
    end
    return res;
  endfunction : decode

  // slot number of an index, the low three bits of it
  function automatic logic [2:0] slot(input logic [7:0] idx);
    return idx[2:0];
  endfunction : slot

  // read value of a slot
  function automatic logic [7:0] read_mux(input regs_state_s s, input logic [2:0] sl,
                                          input sci_pkg::sci_in_s si);
    logic [7:0] v;
    v = sci_pkg::BYTE_RST;
    unique case (sl)
      slot(sci_pkg::IDX_BAUD_HI): begin
        // working bits only, the buffered value is invisible; bit 5 is zero
        v = {s.brk_ie, s.edge_ie, 1'b0, s.div_hi};
      end
      slot(sci_pkg::IDX_BAUD_LO): v = s.div_lo;
      slot(sci_pkg::IDX_CTRL_ONE): v = s.out.ctrl_one;
      slot(sci_pkg::IDX_CTRL_TWO): v = s.out.ctrl_two;
      slot(sci_pkg::IDX_STAT_ONE): v = si.status_one;
      slot(sci_pkg::IDX_STAT_TWO): begin
        v = s.out.stat_cfg;
        v[sci_pkg::BIT_BRK_FLAG] = s.brk_flag;
        v[sci_pkg::BIT_EDGE_FLAG] = s.edge_flag;
        v[sci_pkg::BIT_RX_ACTIVE] = si.rx_active;
      end
      slot(sci_pkg::IDX_CTRL_THREE): begin
        v = s.out.ctrl_three;
        v[sci_pkg::BIT_RX_NINTH] = si.rx_ninth;
      end
      slot(sci_pkg::IDX_DATA): v = si.rx_data;
    endcase
    return v;
  endfunction : read_mux

  //////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [3:0] wdec;
    logic [3:0] rdec;
    logic [7:0] wb;
    logic brk_clr;
    logic edge_clr;
    wdec = 4'h0;
    rdec = 4'h0;
    wb = sci_pkg::BYTE_RST;
    brk_clr = 1'b0;
    edge_clr = 1'b0;
    nxt_st = st_ff;
    nxt_st.out.tx_write = 1'b0;
    nxt_st.out.rx_read = 1'b0;

    // address and data are caught independently, in either order
    if (awvalid && st_ff.awready) begin
      nxt_st.aw_held = 1'b1;
      nxt_st.aw_addr = awaddr;
    end
    if (wvalid && st_ff.wready) begin
      nxt_st.w_held = 1'b1;
      nxt_st.w_byte = wdata[7:0];
      nxt_st.w_lane = wstrb[0];
    end
    if (st_ff.bvalid && bready) begin
      nxt_st.bvalid = 1'b0;
    end

    // both halves present: perform the write one cycle after the later one
    if (st_ff.aw_held && st_ff.w_held && !st_ff.bvalid) begin
      wdec = decode(st_ff.aw_addr);
      wb = st_ff.w_byte;
      nxt_st.aw_held = 1'b0;
      nxt_st.w_held = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = wdec[3] ? sci_pkg::RESP_OKAY : sci_pkg::RESP_SLVERR;
      // a write without the low lane changes nothing but still answers
      if (wdec[3] && st_ff.w_lane) begin
        unique case (wdec[2:0])
          slot(sci_pkg::IDX_BAUD_HI): begin
            nxt_st.brk_ie = wb[sci_pkg::BIT_BRK_IE];
            nxt_st.edge_ie = wb[sci_pkg::BIT_EDGE_IE];
            // working upper bits stay until the low byte arrives
            nxt_st.hi_buf = wb[4:0];
          end
          slot(sci_pkg::IDX_BAUD_LO): begin
            nxt_st.div_hi = st_ff.hi_buf;
            nxt_st.div_lo = wb;
          end
          slot(sci_pkg::IDX_CTRL_ONE): begin
            nxt_st.out.ctrl_one = wb & sci_pkg::CTRL_ONE_MASK;
          end
          slot(sci_pkg::IDX_CTRL_TWO): begin
            nxt_st.out.ctrl_two = wb;
            // first enable of either direction releases the generator
            if (wb[sci_pkg::BIT_TX_ON] || wb[sci_pkg::BIT_RX_ON]) begin
              nxt_st.started = 1'b1;
            end
          end
          slot(sci_pkg::IDX_STAT_ONE): begin
            // read-only byte, write ignored
            nxt_st.bresp = sci_pkg::RESP_OKAY;
          end
          slot(sci_pkg::IDX_STAT_TWO): begin
            // flags clear by writing one
            brk_clr = wb[sci_pkg::BIT_BRK_FLAG];
            edge_clr = wb[sci_pkg::BIT_EDGE_FLAG];
            nxt_st.out.stat_cfg = wb & sci_pkg::STAT_TWO_RW_MASK;
          end
          slot(sci_pkg::IDX_CTRL_THREE): begin
            nxt_st.out.ctrl_three = wb & sci_pkg::CTRL_THREE_RW_MASK;
          end
          slot(sci_pkg::IDX_DATA): begin
            nxt_st.out.tx_data = wb;
            nxt_st.out.tx_write = 1'b1;
          end
        endcase
      end
    end

    // hardware set wins over a software clear in the same cycle
    nxt_st.brk_flag = (st_ff.brk_flag && !brk_clr) || sci_in.break_seen;
    nxt_st.edge_flag = (st_ff.edge_flag && !edge_clr) || sci_in.edge_seen;

    // requests are registered from the next flag and enable, so they change on the same edge as the flag
    nxt_st.out.irq_break = nxt_st.brk_flag && nxt_st.brk_ie;
    nxt_st.out.irq_edge = nxt_st.edge_flag && nxt_st.edge_ie;

    // read channel: one outstanding read, answer registered
    unique case (st_ff.rd_state)
      sci_pkg::RD_IDLE: begin
        if (arvalid && st_ff.arready) begin
          rdec = decode(araddr);
          nxt_st.rd_state = sci_pkg::RD_ANSWER;
          nxt_st.rdata = rdec[3] ? read_mux(st_ff, rdec[2:0], sci_in) : sci_pkg::BYTE_RST;
          nxt_st.rresp = rdec[3] ? sci_pkg::RESP_OKAY : sci_pkg::RESP_SLVERR;
          // engine sees the data register being consumed
          nxt_st.out.rx_read = rdec[3] && (rdec[2:0] == slot(sci_pkg::IDX_DATA));
        end
      end
      sci_pkg::RD_ANSWER: begin
        if (rready) begin
          nxt_st.rd_state = sci_pkg::RD_IDLE;
        end
      end
    endcase

    // readies are registered so every port leaves a flip-flop
    nxt_st.awready = !nxt_st.aw_held && !nxt_st.bvalid;
    nxt_st.wready = !nxt_st.w_held && !nxt_st.bvalid;
    nxt_st.arready = nxt_st.rd_state == sci_pkg::RD_IDLE;
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
      st_ff.rd_state <= sci_pkg::RD_IDLE;
      st_ff.div_lo <= sci_pkg::LOW_DIV_RST;
      st_ff.div_hi <= sci_pkg::HI_DIV_RST;
      st_ff.hi_buf <= sci_pkg::HI_DIV_RST;
      st_ff.started <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // rate generator

  // the reset divisor is non-zero, so the start latch is what holds it off
  rate_gen #(
    .DIV_W(DIV_W)
  ) u_rate_gen (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(st_ff.started),
    .divisor({st_ff.div_hi, st_ff.div_lo}),
    .running(gen_running),
    .os_tick(gen_os),
    .bit_tick(gen_bit)
  );

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign awready = st_ff.awready;
  assign wready = st_ff.wready;
  assign bvalid = st_ff.bvalid;
  assign bresp = st_ff.bresp;
  assign arready = st_ff.arready;
  assign rvalid = st_ff.rd_state == sci_pkg::RD_ANSWER;
  assign rdata = {24'h000000, st_ff.rdata};
  assign rresp = st_ff.rresp;
  assign sci_out = st_ff.out;
  assign rate_running = gen_running;
  assign os_tick = gen_os;
  assign bit_tick = gen_bit;

endmodule : sci_regs

// [dv/sci_regs_assertions.sv]
// port checks for the serial register file
module sci_regs_checker #(
  parameter int unsigned ADDR_W = 12
) (
  input wire logic aclk, // bus clock
  input wire logic aresetn, // reset, active low
  input wire logic awvalid, // write address valid
  input wire logic awready, // write address ready
  input wire logic wvalid, // write data valid
  input wire logic wready, // write data ready
  input wire logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [ADDR_W-1:0] araddr, // read address
  input wire logic arvalid, // read address valid
  input wire logic arready, // read address ready
  input wire logic [31:0] rdata, // read data
  input wire logic [1:0] rresp, // read response
  input wire logic rvalid, // read data valid
  input wire logic rready, // read data ready
  input wire logic rate_running, // generator counting
  input wire logic os_tick, // oversample pulse
  input wire logic bit_tick // bit rate pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  ////////////////////////////////////////
  // aligned address inside either aperture; unaligned ones are refused
  logic ar_map;
  assign ar_map = (araddr[1:0] == 2'h0) &&
    ((araddr >= 12'h260 && araddr <= 12'h27C) || (araddr >= 12'h360 && araddr <= 12'h37C));

  ////////////////////////////////////////
  // bus answers and decode
  a_b_latency: assert property (
    awvalid && awready && wvalid && wready |-> ##2 bvalid) else $error("write answer late");
  a_b_single: assert property (
    bvalid && bready |=> !bvalid) else $error("write answer repeated");
  a_r_latency: assert property (
    arvalid && arready |=> rvalid && !arready) else $error("read answer late");
  a_r_single: assert property (
    rvalid && rready |=> !rvalid) else $error("read answer repeated");
  a_r_upper: assert property (
    rvalid |-> rdata[31:8] == 24'h0) else $error("read upper bits set");
  a_r_decode: assert property (
    arvalid && arready |=> rresp == ($past(ar_map) ? sci_pkg::RESP_OKAY : sci_pkg::RESP_SLVERR))
    else $error("read decode wrong");
  // rate generator
  a_tick_run: assert property (
    bit_tick |-> rate_running) else $error("tick while stopped");
  a_tick_gap: assert property (
    bit_tick |=> !bit_tick [*8]) else $error("bit ticks too close");
  a_os_gap: assert property (
    os_tick |=> !os_tick [*3]) else $error("oversample ticks too close");
  a_start_idle: assert property (
    $rose(aresetn) |-> !rate_running) else $error("generator runs after reset");

  cover property (bit_tick);
  cover property (rvalid && rresp == sci_pkg::RESP_SLVERR);
  cover property (bvalid && bready);
endmodule : sci_regs_checker

bind sci_regs sci_regs_checker #(.ADDR_W(ADDR_W)) chk (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
  .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
  .rresp(rresp), .rvalid(rvalid), .rready(rready), .rate_running(rate_running),
  .os_tick(os_tick), .bit_tick(bit_tick)
);

// [dv/sci_far_model.sv]
// far-side serial engine model: fixed status bytes and event pulses
module sci_far_model (
  input wire logic aclk, // bus clock
  input wire logic brk_req, // bench asks for a break event
  input wire logic edge_req, // bench asks for a receive edge
  output sci_pkg::sci_in_s sci_in // state towards the register file
);
  timeunit 1ns;
  timeprecision 1ps;
  // events are one-cycle pulses, as the real engine gives them
  always_ff @(posedge aclk) begin
    sci_in.status_one <= 8'hA5;
    sci_in.rx_data <= 8'h3C;
    sci_in.rx_ninth <= 1'b0;
    sci_in.rx_active <= 1'b0;
    sci_in.break_seen <= brk_req;
    sci_in.edge_seen <= edge_req;
  end
endmodule : sci_far_model

// [dv/sci_baud_rate_and_register_map_tb_top.sv]
// register-level testbench of the serial register map and rate divisor
module sci_baud_rate_and_register_map_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] BB = sci_pkg::BLOCK_BASE;
  localparam logic [11:0] NB = sci_pkg::NONBLOCK_BASE;
  localparam logic [1:0] OK = sci_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = sci_pkg::RESP_SLVERR;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic brk_req = 1'b0;
  logic edge_req = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, rate_running, os_tick, bit_tick;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  sci_pkg::sci_in_s sci_in;
  sci_pkg::sci_out_s sci_out;
  int error_cnt = 0;
  int n_compared = 0;

  always #5 aclk = ~aclk;

  sci_regs dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(1'b1), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(1'b1), .sci_in(sci_in), .sci_out(sci_out), .rate_running(rate_running),
    .os_tick(os_tick), .bit_tick(bit_tick)
  );

  sci_far_model far (.aclk(aclk), .brk_req(brk_req), .edge_req(edge_req), .sci_in(sci_in));

  ////////////////////////////////////////
  function automatic logic [11:0] adr(input logic [11:0] b, input logic [7:0] i);
    return b + {2'h0, i, 2'h0};
  endfunction : adr

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %0h, seen %0h", nm, e, g);
    end
  endtask : chk

  // bready and rready stay high, so every answer is taken where it is seen
  // no cycle count is assumed: only the watchdog ends a hung wait
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    chk("bresp", er, bresp);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    chk("rdata", {24'h0, e}, rdata);
    chk("rresp", er, rresp);
  endtask : rd

  // count bit and oversample ticks over a span of cycles
  task automatic ticks(input int c, output int t, output int o);
    t = 0;
    o = 0;
    repeat (c) begin
      @(posedge aclk);
      if (bit_tick) t++;
      if (os_tick) o++;
    end
  endtask : ticks

  // skip the first, possibly partial interval, then measure a full one
  task automatic period(output int p);
    int n;
    n = 0;
    p = 0;
    while (!bit_tick && n < 20000) begin
      @(posedge aclk);
      n++;
    end
    @(posedge aclk);
    while (!bit_tick && p < 20000) begin
      @(posedge aclk);
      p++;
    end
    p = p + 1;
  endtask : period

  task automatic poke(input logic b);
    if (b) brk_req <= 1'b1;
    else edge_req <= 1'b1;
    @(posedge aclk);
    brk_req <= 1'b0;
    edge_req <= 1'b0;
    repeat (6) @(posedge aclk);
  endtask : poke

  task automatic end_of_test();
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////
  initial begin
    int p;
    int t;
    int o;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(adr(BB, sci_pkg::IDX_BAUD_HI), 8'h00, OK);
    rd(adr(BB, sci_pkg::IDX_BAUD_LO), 8'h04, OK);
    ticks(300, t, o);
    chk("idle ticks", 0, t);
    chk("idle os ticks", 0, o);
    chk("running", 0, rate_running);
    wr(adr(NB, sci_pkg::IDX_CTRL_TWO), 8'h04, OK);
    rd(adr(BB, sci_pkg::IDX_CTRL_TWO), 8'h04, OK);
    chk("running", 1, rate_running);
    // any 256-cycle window at divisor 4 holds one bit tick and sixteen oversample ticks
    ticks(256, t, o);
    chk("bit ticks div 4", 1, t);
    chk("os ticks div 4", 16, o);
    period(p);
    chk("period div 4", 256, p);
    wr(adr(BB, sci_pkg::IDX_BAUD_HI), 8'hE1, OK);
    rd(adr(BB, sci_pkg::IDX_BAUD_HI), 8'hC0, OK);
    period(p);
    chk("period kept", 256, p);
    wr(adr(BB, sci_pkg::IDX_BAUD_LO), 8'h00, OK);
    rd(adr(NB, sci_pkg::IDX_BAUD_HI), 8'hC1, OK);
    rd(adr(BB, sci_pkg::IDX_BAUD_LO), 8'h00, OK);
    period(p);
    chk("period div 256", 16384, p);
    // enables are live from the high write; flags clear by writing one
    poke(1'b1);
    chk("irq break", 1, sci_out.irq_break);
    chk("irq edge", 0, sci_out.irq_edge);
    wr(adr(BB, sci_pkg::IDX_STAT_TWO), 8'h80, OK);
    repeat (2) @(posedge aclk);
    chk("irq break", 0, sci_out.irq_break);
    poke(1'b0);
    chk("irq edge", 1, sci_out.irq_edge);
    wr(adr(BB, sci_pkg::IDX_STAT_TWO), 8'h40, OK);
    wr(adr(BB, sci_pkg::IDX_BAUD_HI), 8'h01, OK);
    poke(1'b1);
    chk("irq masked", 0, sci_out.irq_break);
    rd(adr(BB, sci_pkg::IDX_STAT_TWO), 8'h80, OK);
    // map, masks, read-only slot and refused addresses
    wr(adr(BB, sci_pkg::IDX_CTRL_ONE), 8'hFF, OK);
    rd(adr(NB, sci_pkg::IDX_CTRL_ONE), 8'hB7, OK);
    wr(adr(BB, sci_pkg::IDX_STAT_ONE), 8'h00, OK);
    rd(adr(BB, sci_pkg::IDX_STAT_ONE), 8'hA5, OK);
    wr(adr(NB, sci_pkg::IDX_DATA), 8'h5A, OK);
    chk("tx data", 8'h5A, sci_out.tx_data);
    chk("tx write", 1, sci_out.tx_write);
    rd(adr(NB, sci_pkg::IDX_DATA), 8'h3C, OK);
    chk("rx read", 1, sci_out.rx_read);
    wr(adr(BB, sci_pkg::IDX_CTRL_THREE), 8'hFF, OK);
    rd(adr(NB, sci_pkg::IDX_CTRL_THREE), 8'h7F, OK);
    rd(12'h280, 8'h00, ERR);
    wr(12'h3FC, 8'h55, ERR);
    // zero divisor must stop the generator
    wr(adr(BB, sci_pkg::IDX_BAUD_HI), 8'h00, OK);
    wr(adr(BB, sci_pkg::IDX_BAUD_LO), 8'h00, OK);
    ticks(300, t, o);
    chk("zero div ticks", 0, t);
    chk("zero div os ticks", 0, o);
    chk("running", 0, rate_running);
    end_of_test();
  end

  // watchdog sized well beyond the longest rate measurement
  initial begin
    repeat (60000) @(posedge aclk);
    error_cnt++;
    $display("unexpected run length: expected end, seen timeout");
    end_of_test();
  end
endmodule : sci_baud_rate_and_register_map_tb_top
